// ===== src/cpd_column_decoder.sv
// Column and secondary packet decoder with an AXI4-Lite register slave.
`timescale 1ns/10ps
// What this block does
// - Column packets are acted on only in the attention power state.
// - Foreign device or opcode x000 only retires the write buffer.
// - Opcode x001 retires the buffer, then writes column into buffer.
// - Opcode x011 reads the addressed column of the addressed bank.
// - Opcode x100 retires the buffer, then precharges the bank.
// - Opcode x101 writes, then precharges after the buffer retires.
// - Opcode x111 reads, then precharges the bank automatically.
// - Opcode top bit moves the device to standby, combinable.
// - Write buffer retires automatically, no explicit command needed.
// - Mask bit set: secondary packet holds two byte masks for writes.
// - Mask bit clear: extended packet, ignored unless device matches.
// - Extended opcode 1xxx0 precharges the extended bank.
// - x10x0 drives calibration; x11x0 also samples and updates.
// - Extended xxx10 moves to standby, combinable with precharge.
// - Mask bit one writes its byte; bit zero is earliest.
// - Framing bit marks the command and its secondary packet.
module cpd_column_decoder
  import cpd_pkg::*;
#(
  parameter int unsigned BANK_W = 5,
  parameter int unsigned COL_W  = 7
) (
  input  wire logic              aclk,          // System clock.
  input  wire logic              aresetn,       // Synchronous reset, low.
  input  wire logic              link_clk,      // Interface clock pin.
  input  wire logic [CMD_W-1:0]  col_cmd_pin,   // Column command packet.
  input  wire logic [SEC_W-1:0]  col_sec_pin,   // Mask or extended packet.
  input  wire logic              attention_state_set,      // Pulse from row decoder.
  output logic                   retire_q,      // Retire write buffer.
  output logic                   wr_q,          // Write to buffer.
  output logic                   rd_q,          // Column read.
  output logic                   pre_q,         // Precharge bank_q.
  output logic                   pre_after_q,   // Precharge after op.
  output logic [BANK_W-1:0]      bank_q,        // Addressed bank.
  output logic [COL_W-1:0]       col_q,         // Addressed column.
  output logic [7:0]             mask_a_q,      // Lane A byte mask.
  output logic [7:0]             mask_b_q,      // Lane B byte mask.
  output logic                   xpre_q,        // Extended precharge.
  output logic [BANK_W-1:0]      xbank_q,       // Extended bank.
  output logic                   cal_q,         // Drive calibration.
  output logic                   sam_q,         // Sample and update.
  output logic                   attention_q,   // In attention state.
  input  wire logic [7:0]        s_axi_awaddr,  // Write address.
  input  wire logic              s_axi_awvalid, // Write address valid.
  output logic                   s_axi_awready, // Write address ready.
  input  wire logic [31:0]       s_axi_wdata,   // Write data.
  input  wire logic [3:0]        s_axi_wstrb,   // Write strobes.
  input  wire logic              s_axi_wvalid,  // Write data valid.
  output logic                   s_axi_wready,  // Write data ready.
  output logic [1:0]             s_axi_bresp,   // Write response.
  output logic                   s_axi_bvalid,  // Write response valid.
  input  wire logic              s_axi_bready,  // Write response ready.
  input  wire logic [7:0]        s_axi_araddr,  // Read address.
  input  wire logic              s_axi_arvalid, // Read address valid.
  output logic                   s_axi_arready, // Read address ready.
  output logic [31:0]            s_axi_rdata,   // Read data.
  output logic [1:0]             s_axi_rresp,   // Read response.
  output logic                   s_axi_rvalid,  // Read data valid.
  input  wire logic              s_axi_rready   // Read data ready.
);

  // Every check below runs on the system clock and sleeps through reset.
  default clocking cb_sys @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Device field comparison shared by both packet kinds.
  function automatic logic dev_match(input logic [4:0] f,
                                     input logic [4:0] id);
    return f == id;
  endfunction

  // Two-stage synchronisers for the link clock and packet pins.
  logic [2:0]       lclk_q;
  logic [CMD_W-1:0] cmd_s1_q, cmd_s2_q;
  logic [SEC_W-1:0] sec_s1_q, sec_s2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lclk_q   <= '0;
      cmd_s1_q <= '0;
      cmd_s2_q <= '0;
      sec_s1_q <= '0;
      sec_s2_q <= '0;
    end else begin
      lclk_q   <= {lclk_q[1:0], link_clk};
      cmd_s1_q <= col_cmd_pin;
      cmd_s2_q <= cmd_s1_q;
      sec_s1_q <= col_sec_pin;
      sec_s2_q <= sec_s1_q;
    end
  end

  // Rising link edge seen on the synchronised copies only.
  logic link_rise;
  assign link_rise = lclk_q[1] & ~lclk_q[2];

  // Registers: device id and enable written by software; count, last opcode and power state set by the decoder.
  logic [4:0]    devid_q;
  logic          enable_q;
  logic [15:0]   cmd_count_q;
  logic [3:0]    last_op_q;
  cpd_power_type power_q;

  // Decoded fields of the captured packets.
  logic       frame;
  logic [4:0] cdev, xdev;
  logic [3:0] cop;
  logic [4:0] xop;
  logic       cmatch, xmatch, is_mask, live;
  assign frame   = cmd_s2_q[CC_FRAME_BIT];
  assign cdev    = cmd_s2_q[CC_DEV_LO +: 5];
  assign cop     = cmd_s2_q[CC_OP_LO +: 4];
  assign is_mask = sec_s2_q[SX_M_BIT];
  assign xdev    = sec_s2_q[SX_DEV_LO +: 5];
  assign xop     = sec_s2_q[4:0];
  // Packets count only on a link edge, while enabled and attentive.
  assign live    = link_rise & frame & enable_q
                   & (power_q == ST_ATTENTION);
  assign cmatch  = dev_match(cdev, devid_q);
  assign xmatch  = dev_match(xdev, devid_q) & ~is_mask;

  // Column command decode; every live packet except a matched read retires the buffer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retire_q    <= 1'b0;
      wr_q        <= 1'b0;
      rd_q        <= 1'b0;
      pre_q       <= 1'b0;
      pre_after_q <= 1'b0;
      bank_q      <= '0;
      col_q       <= '0;
      last_op_q   <= '0;
    end else begin
      retire_q    <= 1'b0;
      wr_q        <= 1'b0;
      rd_q        <= 1'b0;
      pre_q       <= 1'b0;
      pre_after_q <= 1'b0;
      if (live) begin
        // Foreign packets only retire, giving automatic retirement.
        retire_q <= 1'b1;
        if (cmatch) begin
          bank_q    <= cmd_s2_q[CC_BANK_LO +: BANK_W];
          col_q     <= cmd_s2_q[CC_COL_LO +: COL_W];
          last_op_q <= cop;
          case (cop[2:0])
            COP_NOP:  retire_q <= 1'b1;
            COP_WR:   wr_q <= 1'b1;
            COP_RD: begin
              retire_q <= 1'b0;
              rd_q     <= 1'b1;
            end
            COP_COLUMN_PRECHARGE: pre_q <= 1'b1;
            COP_WRA: begin
              wr_q        <= 1'b1;
              pre_after_q <= 1'b1;
            end
            COP_RDA: begin
              retire_q    <= 1'b0;
              rd_q        <= 1'b1;
              pre_after_q <= 1'b1;
            end
            default: retire_q <= 1'b1;
          endcase
        end
      end
    end
  end

  // Byte masks apply to write commands; no mask packet means all bytes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_a_q <= '1;
      mask_b_q <= '1;
    end else if (live && cmatch) begin
      if (is_mask) begin
        mask_a_q <= sec_s2_q[7:0];
        mask_b_q <= sec_s2_q[SX_MB_LO +: 8];
      end else begin
        mask_a_q <= '1;
        mask_b_q <= '1;
      end
    end
  end

  // Extended packet decode; the lowest opcode bit marks it reserved.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xpre_q  <= 1'b0;
      xbank_q <= '0;
      cal_q   <= 1'b0;
      sam_q   <= 1'b0;
    end else begin
      xpre_q <= 1'b0;
      cal_q  <= 1'b0;
      sam_q  <= 1'b0;
      if (live && xmatch && !xop[XOP_RSV_BIT]) begin
        xbank_q <= sec_s2_q[SX_BANK_LO +: BANK_W];
        xpre_q  <= xop[XOP_PRE_BIT];
        cal_q   <= xop[XOP_CAL_BIT];
        sam_q   <= xop[XOP_CAL_BIT] & xop[XOP_SAM_BIT];
      end
    end
  end

  // Power state: relax from either packet wins over attention.
  logic relax_c, relax_x;
  assign relax_c = live & cmatch & cop[COP_RLX_BIT];
  assign relax_x = live & xmatch & ~xop[XOP_RSV_BIT]
                   & xop[XOP_RLX_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_q     <= ST_STANDBY;
      attention_q <= 1'b0;
    end else begin
      if (relax_c || relax_x) begin
        power_q     <= ST_STANDBY;
        attention_q <= 1'b0;
      end else if (attention_state_set) begin
        power_q     <= ST_ATTENTION;
        attention_q <= 1'b1;
      end
    end
  end

  // Count of matched column packets, for software visibility.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_count_q <= '0;
    end else if (live && cmatch) begin
      cmd_count_q <= cmd_count_q + 16'h0001;
    end
  end

  // AXI4-Lite write: address and data taken in either order.
  logic       aw_held_q, w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       do_write;
  assign do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_held_q && !s_axi_awready) begin
        aw_held_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && !w_held_q && !s_axi_wready) begin
        w_held_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
    end
  end

  // Control register and write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      devid_q      <= DEVID_RST;
      enable_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q == A_CTRL) ? RESP_OK : RESP_ERR;
        if (aw_addr_q == A_CTRL && w_strb_q[0]) begin
          devid_q  <= w_data_q[4:0];
          enable_q <= w_data_q[7];
        end
      end
    end
  end

  // Read path; a read is answered in the same cycle its address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OK;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OK;
        case (s_axi_araddr)
          A_CTRL:    s_axi_rdata <= {24'h000000, enable_q, 2'h0, devid_q};
          A_STATUS:  s_axi_rdata <= {31'h00000000, attention_q};
          A_LASTCMD: s_axi_rdata <= {28'h0000000, last_op_q};
          A_MASK:    s_axi_rdata <= {16'h0000, mask_b_q, mask_a_q};
          A_COUNT:   s_axi_rdata <= {16'h0000, cmd_count_q};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_ERR;
          end
        endcase
      end
    end
  end

  // Checks on decode behaviour.
  a_no_cmd_standby: assert property (
    (power_q == ST_STANDBY) |=> !wr_q && !rd_q && !pre_q)
    else $error("Command acted on in standby.");
  a_foreign_retire: assert property (
    (live && !cmatch) |=> retire_q && !wr_q && !rd_q && !pre_q)
    else $error("Foreign packet did more than retire.");
  a_write_retire: assert property (
    (live && cmatch && cop[2:0] == COP_WR) |=> wr_q && retire_q)
    else $error("Write did not retire and load buffer.");
  a_read_issue: assert property (
    (live && cmatch && cop[2:0] == COP_RD) |=> rd_q && !pre_after_q)
    else $error("Read not issued.");
  a_column_precharge_issue: assert property (
    (live && cmatch && cop[2:0] == COP_COLUMN_PRECHARGE) |=> pre_q && retire_q)
    else $error("Precharge not issued.");
  a_wra_issue: assert property (
    (live && cmatch && cop[2:0] == COP_WRA) |=> wr_q && pre_after_q)
    else $error("Write with precharge not issued.");
  a_rda_issue: assert property (
    (live && cmatch && cop[2:0] == COP_RDA) |=> rd_q && pre_after_q)
    else $error("Read with precharge not issued.");
  a_relax_state: assert property (
    (relax_c || relax_x) |=> !attention_q ##1 1'b1)
    else $error("Relax did not reach standby.");
  a_mask_load: assert property (
    (live && cmatch && is_mask) |=> mask_a_q == $past(sec_s2_q[7:0]))
    else $error("Byte mask not captured.");
  a_xpre_bank: assert property (
    (live && xmatch && xop[XOP_PRE_BIT] && !xop[XOP_RSV_BIT])
      |=> xpre_q && xbank_q == $past(sec_s2_q[SX_BANK_LO +: BANK_W]))
    else $error("Extended precharge wrong.");
  a_sam_needs_cal: assert property (
    (live && xmatch && !xop[XOP_RSV_BIT] && xop[XOP_CAL_BIT])
      |=> cal_q && sam_q == $past(xop[XOP_SAM_BIT]))
    else $error("Calibrate or sample not issued.");
  a_xrsv_quiet: assert property (
    (live && xop[XOP_RSV_BIT]) |=> !xpre_q && !cal_q)
    else $error("Reserved extended opcode acted.");
endmodule

// ===== src/cpd_pkg.sv
// Package of field layouts, opcodes and register map for the column decoder.
package cpd_pkg;
  // Packet widths on the column link.
  localparam int unsigned CMD_W        = 24;
  localparam int unsigned SEC_W        = 17;
  // Column command packet layout.
  localparam int unsigned CC_FRAME_BIT = 23;
  localparam int unsigned CC_DEV_LO    = 18;
  localparam int unsigned CC_BANK_LO   = 13;
  localparam int unsigned CC_COL_LO    = 6;
  localparam int unsigned CC_OP_LO     = 2;
  // Secondary packet layout.
  localparam int unsigned SX_M_BIT     = 16;
  localparam int unsigned SX_MB_LO     = 8;
  localparam int unsigned SX_DEV_LO    = 10;
  localparam int unsigned SX_BANK_LO   = 5;
  // Column opcode low three bits.
  localparam logic [2:0] COP_NOP   = 3'h0;
  localparam logic [2:0] COP_WR    = 3'h1;
  localparam logic [2:0] COP_RD    = 3'h3;
  localparam logic [2:0] COP_COLUMN_PRECHARGE  = 3'h4;
  localparam logic [2:0] COP_WRA   = 3'h5;
  localparam logic [2:0] COP_RDA   = 3'h7;
  localparam int unsigned COP_RLX_BIT = 3;
  // Extended opcode bits.
  localparam int unsigned XOP_PRE_BIT = 4;
  localparam int unsigned XOP_SAM_BIT = 2;
  localparam int unsigned XOP_CAL_BIT = 3;
  localparam int unsigned XOP_RLX_BIT = 1;
  localparam int unsigned XOP_RSV_BIT = 0;
  // AXI4-Lite register byte addresses.
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_LASTCMD = 8'h08;
  localparam logic [7:0] A_MASK    = 8'h0c;
  localparam logic [7:0] A_COUNT   = 8'h10;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;
  localparam logic [4:0] DEVID_RST = 5'h00;
  typedef enum logic {ST_STANDBY, ST_ATTENTION} cpd_power_type;
endpackage

// ===== verif/cpd_ctrl_model.sv
// Behavioural column-link controller that frames packets on its own clock.
`timescale 1ns/10ps
module cpd_ctrl_model
  import cpd_pkg::*;
(
  output logic             link_clk,    // Interface clock, still when idle.
  output logic [CMD_W-1:0] col_cmd_pin, // Column command packet.
  output logic [SEC_W-1:0] col_sec_pin  // Mask or extended packet.
);
  // Pins start low with the frame bit clear, so nothing is framed.
  initial begin
    link_clk    = 1'b0;
    col_cmd_pin = '0;
    col_sec_pin = '0;
  end
  // One packet per link edge, held well past the edge for the synchroniser.
  // Afterwards the pins carry the inverse of the packet, so stale data
  // cannot pass for a fresh packet in a decoder that samples too late.
  task automatic send(input logic [CMD_W-1:0] c, input logic [SEC_W-1:0] s);
    // Callers start on a system clock edge; step off it so no pin races it.
    #2.5;
    col_cmd_pin = {c[CMD_W-1:2], 2'h0};
    col_sec_pin = s;
    #62.5 link_clk = 1'b1;
    #62.5 link_clk = 1'b0;
    #20 col_cmd_pin = ~col_cmd_pin;
    col_sec_pin = ~col_sec_pin;
  endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the column packet decoder and its registers.
`timescale 1ns/10ps
module tb_top;
  import cpd_pkg::*;
  localparam logic [4:0] DEV = 5'h15;
  logic aclk, aresetn, attention_state_set, link_clk, clr;
  logic [CMD_W-1:0] col_cmd_pin, cmd;
  logic [SEC_W-1:0] col_sec_pin, sec;
  logic retire_q, wr_q, rd_q, pre_q, pre_after_q, xpre_q, cal_q, sam_q;
  logic attention_q, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [4:0] bank_q, xbank_q, b;
  logic [6:0] col_q, cl;
  logic [7:0] mask_a_q, mask_b_q, awaddr, araddr, seen, ma;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  int n_mismatch, check_count, i;
  // Expected pulses {retire,wr,rd,pre,pre_after,xpre,cal,sam} and care masks.
  logic [7:0] ce [8] = '{8'h80, 8'hc0, 8'h00, 8'h20,
                         8'h90, 8'h48, 8'h00, 8'h28};
  logic [7:0] cm [8] = '{8'hff, 8'hff, 8'h7f, 8'hff,
                         8'hff, 8'h7f, 8'h7f, 8'hff};
  // Calibrate alone is 0x08: opcode bit 3 set, bit 2 clear.
  logic [4:0] xo [6] = '{5'h10, 5'h08, 5'h0c, 5'h01, 5'h1f, 5'h12};
  logic [7:0] xe [6] = '{8'h84, 8'h82, 8'h83, 8'h80, 8'h80, 8'h84};

  cpd_column_decoder u_dut (.aclk(aclk), .aresetn(aresetn),
    .link_clk(link_clk), .col_cmd_pin(col_cmd_pin), .col_sec_pin(col_sec_pin),
    .attention_state_set(attention_state_set), .retire_q(retire_q), .wr_q(wr_q), .rd_q(rd_q),
    .pre_q(pre_q), .pre_after_q(pre_after_q), .bank_q(bank_q), .col_q(col_q),
    .mask_a_q(mask_a_q), .mask_b_q(mask_b_q), .xpre_q(xpre_q),
    .xbank_q(xbank_q), .cal_q(cal_q), .sam_q(sam_q),
    .attention_q(attention_q), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  cpd_ctrl_model u_ctrl (.link_clk(link_clk), .col_cmd_pin(col_cmd_pin),
    .col_sec_pin(col_sec_pin));

  // Free-running system clock, 10 ns period.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Pulses last one cycle, so they are collected into a sticky vector.
  always @(posedge aclk) begin
    if (clr) seen <= 8'h00;
    else seen <= seen | {retire_q, wr_q, rd_q, pre_q, pre_after_q,
                         xpre_q, cal_q, sam_q};
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Ready is looked at mid-cycle; the handshake completes at the next edge.
  // Only the watchdog ends a wait; the tasks assume no answer time.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic attention_state;
    @(posedge aclk);
    attention_state_set <= 1'b1;
    @(posedge aclk);
    attention_state_set <= 1'b0;
    repeat (2) @(negedge aclk);
    chk("attention set", 32'h1, {31'h0, attention_q});
  endtask
  // Sends one packet, then checks the pulses it caused and the power state.
  task automatic pkt(input logic [7:0] e, input logic [7:0] m, input logic a);
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    u_ctrl.send(cmd, sec);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("pulses", {24'h0, e}, {24'h0, seen & m});
    chk("attention", {31'h0, a}, {31'h0, attention_q});
  endtask
  function automatic logic [CMD_W-1:0] cc(input logic [4:0] d,
    input logic [4:0] bk, input logic [6:0] c, input logic [3:0] op);
    return {1'b1, d, bk, c, op, 2'h0};
  endfunction
  function automatic logic [SEC_W-1:0] sx(input logic [4:0] d,
    input logic [4:0] bk, input logic [4:0] op);
    return {2'b00, d, bk, op};
  endfunction

  // A hang past about twenty times the expected run length ends the test as failed.
  initial begin
    #100000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    aresetn = 1'b0;
    attention_state_set = 1'b0;
    clr = 1'b1;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    n_mismatch = 0;
    check_count = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("mask_a reset", 32'hff, {24'h0, mask_a_q});
    axi_rd(A_CTRL, rd, resp);
    chk("ctrl reset", 32'h0, rd);
    axi_rd(8'h14, rd, resp);
    chk("rresp unmapped", {30'h0, RESP_ERR}, {30'h0, resp});
    chk("rdata unmapped", 32'h0, rd);
    axi_wr(8'h14, 32'h9f, resp);
    chk("bresp unmapped", {30'h0, RESP_ERR}, {30'h0, resp});
    axi_wr(A_CTRL, {24'h0, 3'b100, DEV}, resp);
    chk("bresp ctrl", {30'h0, RESP_OK}, {30'h0, resp});
    axi_rd(A_CTRL, rd, resp);
    chk("ctrl", {24'h0, 3'b100, DEV}, {24'h0, rd[7:0]});
    // Still in standby: a matched write is ignored.
    cmd = cc(DEV, 5'h02, 7'h11, 4'h1);
    sec = {1'b1, 16'h0000};
    pkt(8'h00, 8'hff, 1'b0);
    attention_state;
    // Every column opcode with the relax bit clear.
    for (i = 0; i < 8; i++) begin
      b = 5'h1f - 5'(i);
      cl = 7'h7f ^ 7'(i * 9);
      ma = 8'(1 << i);
      cmd = cc(DEV, b, cl, {1'b0, 3'(i)});
      sec = {1'b1, ~ma, ma};
      pkt(ce[i], cm[i], 1'b1);
      if (i % 2 == 1) begin
        chk("bank", {27'h0, b}, {27'h0, bank_q});
        chk("column", {25'h0, cl}, {25'h0, col_q});
      end
      if (i == 1 || i == 5) begin
        chk("mask a", {24'h0, ma}, {24'h0, mask_a_q});
        chk("mask b", {24'h0, ~ma}, {24'h0, mask_b_q});
      end
    end
    // Device field differing only in its top bit is foreign.
    cmd = cc(DEV ^ 5'h10, 5'h01, 7'h01, 4'h3);
    pkt(8'h80, 8'hff, 1'b1);
    // Extended opcodes, the last combining precharge with relax.
    for (i = 0; i < 6; i++) begin
      cmd = cc(DEV, 5'h00, 7'h00, 4'h0);
      sec = sx(DEV, 5'h1f - 5'(i), xo[i]);
      pkt(xe[i], 8'hff, i != 5);
      if (i == 0 || i == 5)
        chk("xbank", {27'h0, 5'h1f - 5'(i)}, {27'h0, xbank_q});
    end
    attention_state;
    sec = sx(DEV ^ 5'h01, 5'h03, 5'h10);
    pkt(8'h80, 8'hff, 1'b1);
    // Write combined with relax, then a read that standby must ignore.
    cmd = cc(DEV, 5'h04, 7'h05, 4'h9);
    sec = {1'b1, 16'hffff};
    pkt(8'hc0, 8'hff, 1'b0);
    cmd = cc(DEV, 5'h04, 7'h05, 4'h3);
    pkt(8'h00, 8'hff, 1'b0);
    axi_rd(A_LASTCMD, rd, resp);
    chk("last opcode", 32'h9, {28'h0, rd[3:0]});
    axi_rd(A_COUNT, rd, resp);
    chk("matched count", 32'd16, {16'h0, rd[15:0]});
    axi_rd(A_STATUS, rd, resp);
    chk("status", 32'h0, {31'h0, rd[0]});
    // With the decoder disabled even an attentive device ignores packets.
    axi_wr(A_CTRL, {24'h0, 3'b000, DEV}, resp);
    chk("bresp disable", {30'h0, RESP_OK}, {30'h0, resp});
    attention_state;
    cmd = cc(DEV, 5'h04, 7'h05, 4'h1);
    pkt(8'h00, 8'hff, 1'b1);
    end_of_test;
  end
endmodule
